// >>> rtl/cao_pkg.sv
package cao_pkg;

  // ==========================================================
  // Register bus
  localparam int unsigned AVS_ADDR_W = 8;
  localparam int unsigned AVS_DATA_W = 32;
  localparam logic [7:0] IDX_PHASE_DIV = 8'h2E;
  localparam logic [7:0] IDX_HIZ = 8'h2F;
  localparam logic [7:0] IDX_AUDIO = 8'h31;
  localparam logic [7:0] IDX_RATE = 8'h32;

  // ==========================================================
  // Field layout
  localparam int unsigned HALF_BIT = 0;
  localparam int unsigned QUARTER_BIT = 1;
  localparam int unsigned PHASE_LSB = 2;
  localparam int unsigned PHASE_MSB = 5;
  localparam int unsigned HOST_RATE_BIT = 2;
  localparam int unsigned MID_EN_BIT = 5;
  localparam int unsigned WINDOW_LSB = 7;
  localparam int unsigned WINDOW_MSB = 9;
  localparam logic [9:0] AUDIO_WMASK = 10'h3A4;

  // ==========================================================
  // Reset values and codes
  localparam logic [5:0] PHASE_DIV_RST = 6'h00;
  localparam logic [1:0] HIZ_RST = 2'h0;
  localparam logic [1:0] HIZ_OFF = 2'h3;
  localparam logic [9:0] AUDIO_RST = 10'h100;
  localparam logic [2:0] WINDOW_RST = 3'h2;
  localparam logic [2:0] RATE_RST = 3'h3;
  localparam int unsigned PHASE_STEP_PS = 700;

  typedef enum logic [1:0]
  {
    CAO_BUS_IDLE = 2'b01,
    CAO_BUS_ACK = 2'b10
  } cao_bus_state_type;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx[5:0], 2'h0};
  endfunction

  function automatic logic [15:0] merge_lanes(input logic [15:0] old,
    input logic [31:0] wd, input logic [3:0] be);
    merge_lanes[7:0] = be[0] ? wd[7:0] : old[7:0];
    merge_lanes[15:8] = be[1] ? wd[15:8] : old[15:8];
  endfunction

endpackage

// >>> rtl/cao_clk_if.sv
`timescale 1ns/100ps
interface cao_clk_if;
  logic video_tick;
  logic [1:0] div_sel;
  logic aclk_tick;
  logic mid_tick;
  logic mid_en;
  logic third_duty;
  logic vclk_p;
  logic vclk_n;
  logic aclk512;
  logic aclk384;
  logic aclk192;

  modport ctrl
  (
    output video_tick, div_sel, aclk_tick, mid_tick, mid_en, third_duty,
    input vclk_p, vclk_n, aclk512, aclk384, aclk192
  );

  modport gen
  (
    input video_tick, div_sel, aclk_tick, mid_tick, mid_en, third_duty,
    output vclk_p, vclk_n, aclk512, aclk384, aclk192
  );
endinterface

// >>> rtl/cao_clkgen.sv
`timescale 1ns/100ps
module cao_clkgen
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Settings in, clocks out
  cao_clk_if.gen clk_if
);

  typedef struct packed {
    logic [1:0] vcnt;
    logic vclk;
    logic [1:0] acnt;
    logic a512;
    logic a384;
    logic a192;
  } cao_gen_state_type;

  cao_gen_state_type st_ff;
  cao_gen_state_type nxt_st;

  // ==========================================================
  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    if (clk_if.video_tick)
    begin
      nxt_st.vcnt = st_ff.vcnt + 2'h1;
      if (clk_if.div_sel == 2'h2)
      begin
        if (st_ff.vcnt == 2'h3)
        begin
          nxt_st.vclk = ~st_ff.vclk;
        end
      end
      else if (clk_if.div_sel == 2'h1)
      begin
        if (st_ff.vcnt[0])
        begin
          nxt_st.vclk = ~st_ff.vclk;
        end
      end
      else
      begin
        // Both bits set, and also neither, give the undivided clock
        nxt_st.vclk = ~st_ff.vclk;
      end
    end
    if (clk_if.aclk_tick)
    begin
      if (clk_if.third_duty)
      begin
        nxt_st.acnt = (st_ff.acnt == 2'h2) ? 2'h0 : st_ff.acnt + 2'h1;
        nxt_st.a512 = (nxt_st.acnt == 2'h0);
      end
      else
      begin
        nxt_st.acnt = 2'h0;
        nxt_st.a512 = ~st_ff.a512;
      end
    end
    if (!clk_if.mid_en)
    begin
      nxt_st.a384 = 1'b0;
      nxt_st.a192 = 1'b0;
    end
    else if (clk_if.mid_tick)
    begin
      nxt_st.a384 = ~st_ff.a384;
      nxt_st.a192 = st_ff.a384 ? ~st_ff.a192 : st_ff.a192;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign clk_if.vclk_p = st_ff.vclk;
  assign clk_if.vclk_n = ~st_ff.vclk;
  assign clk_if.aclk512 = st_ff.a512;
  assign clk_if.aclk384 = st_ff.a384;
  assign clk_if.aclk192 = st_ff.a192;

endmodule

// >>> rtl/cao_clock_output_audio_ctrl.sv
// How it works
// - Quarter bit alone divides video clock by four
// - Half bit alone divides video clock by two
// - Both divider bits set give full rate
// - Phase field sets delay in 700ps steps
// - Output disable code 11b floats the pair
// - Drift window field resets to 010b
// - Bit five enables the 384fs/192fs clocks
// - 512fs becomes 33% duty at 96kHz while bit five is set
// - Host override bit replaces the rate pins
// - Host rate code resets to 48kHz code
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
module cao_clock_output_audio_ctrl
#(
  parameter logic [2:0] RATE_CODE_96K = 3'h5
)
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [cao_pkg::AVS_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [cao_pkg::AVS_DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [cao_pkg::AVS_DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Clock synthesiser ticks
  input wire logic i_video_tick,
  input wire logic i_aclk512_tick,
  input wire logic i_mid_tick,
  // External sample-rate pins
  input wire logic [2:0] i_audio_rate_pins,
  // Differential video clock pair
  output logic o_diff_video_clock_out_p,
  output logic o_diff_video_clock_out_n,
  output logic o_diff_video_clock_out_oe,
  output logic [3:0] o_diff_clk_phase_sel,
  // Audio clock control
  output logic [2:0] o_frame_seq_drift_window,
  output logic o_mid_audio_clock_enable,
  output logic [2:0] o_audio_rate,
  output logic o_aclk512,
  output logic o_aclk384,
  output logic o_aclk192
);

  typedef struct packed {
    cao_pkg::cao_bus_state_type bus;
    logic [31:0] rdata;
    logic [5:0] phase_div;
    logic [1:0] hiz;
    logic [9:0] audio;
    logic [2:0] rate_reg;
    logic rate_written;
    logic [2:0] pins_meta;
    logic [2:0] pins_sync;
    logic [2:0] rate_eff;
    logic vclk_q;
    logic [1:0] div_q;
    logic [2:0] vgap;
    logic vsettle;
    logic a512_q;
    logic mode_q;
    logic [1:0] agap;
    logic asettle;
  } cao_state_type;

  cao_state_type st_ff;
  cao_state_type nxt_st;

  cao_clk_if clk_if();

  logic bus_req;
  logic wr_ack;
  logic [31:0] rd_word;
  logic [15:0] merged;
  logic vchanged;
  logic achanged;
  logic third_duty;

  // ==========================================================
  // Clock generator
  cao_clkgen u_clkgen
  (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .clk_if(clk_if.gen)
  );

  assign clk_if.video_tick = i_video_tick;
  assign clk_if.aclk_tick = i_aclk512_tick;
  assign clk_if.mid_tick = i_mid_tick;
  assign clk_if.div_sel = {st_ff.phase_div[cao_pkg::QUARTER_BIT],
                           st_ff.phase_div[cao_pkg::HALF_BIT]};
  assign clk_if.mid_en = st_ff.audio[cao_pkg::MID_EN_BIT];
  // Duty change follows the effective rate, pins or host code
  assign third_duty = st_ff.audio[cao_pkg::MID_EN_BIT] &&
                      (st_ff.rate_eff == RATE_CODE_96K);
  assign clk_if.third_duty = third_duty;

  // ==========================================================
  // Register access and next state
  always_comb
  begin
    nxt_st = st_ff;
    bus_req = i_avs_read | i_avs_write;
    wr_ack = (st_ff.bus == cao_pkg::CAO_BUS_ACK) && i_avs_write;
    rd_word = 32'h0;
    merged = 16'h0;
    case (i_avs_address)
      cao_pkg::reg_addr(cao_pkg::IDX_PHASE_DIV):
      begin
        rd_word = {26'h0, st_ff.phase_div};
      end
      cao_pkg::reg_addr(cao_pkg::IDX_HIZ):
      begin
        rd_word = {30'h0, st_ff.hiz};
      end
      cao_pkg::reg_addr(cao_pkg::IDX_AUDIO):
      begin
        rd_word = {22'h0, st_ff.audio};
      end
      cao_pkg::reg_addr(cao_pkg::IDX_RATE):
      begin
        rd_word = {29'h0, st_ff.rate_reg};
      end
      default:
      begin
        rd_word = 32'h0;
      end
    endcase
    merged = cao_pkg::merge_lanes(rd_word[15:0], i_avs_writedata,
                                  i_avs_byteenable);

    case (st_ff.bus)
      cao_pkg::CAO_BUS_IDLE:
      begin
        if (bus_req)
        begin
          nxt_st.bus = cao_pkg::CAO_BUS_ACK;
          if (i_avs_read)
          begin
            nxt_st.rdata = rd_word;
          end
        end
      end
      cao_pkg::CAO_BUS_ACK:
      begin
        nxt_st.bus = cao_pkg::CAO_BUS_IDLE;
      end
      default:
      begin
        nxt_st.bus = cao_pkg::CAO_BUS_IDLE;
      end
    endcase

    // Reserved bits are dropped so they always read back as zero
    if (wr_ack)
    begin
      case (i_avs_address)
        cao_pkg::reg_addr(cao_pkg::IDX_PHASE_DIV):
        begin
          nxt_st.phase_div = merged[5:0];
        end
        cao_pkg::reg_addr(cao_pkg::IDX_HIZ):
        begin
          nxt_st.hiz = merged[1:0];
        end
        cao_pkg::reg_addr(cao_pkg::IDX_AUDIO):
        begin
          nxt_st.audio = merged[9:0] & cao_pkg::AUDIO_WMASK;
        end
        cao_pkg::reg_addr(cao_pkg::IDX_RATE):
        begin
          nxt_st.rate_reg = merged[2:0];
          nxt_st.rate_written = 1'b1;
        end
        default:
        begin
          nxt_st.rate_written = st_ff.rate_written;
        end
      endcase
    end

    // Rate pins come from off chip and are synchronised first
    nxt_st.pins_meta = i_audio_rate_pins;
    nxt_st.pins_sync = st_ff.pins_meta;
    nxt_st.rate_eff = st_ff.audio[cao_pkg::HOST_RATE_BIT] ?
                      st_ff.rate_reg : st_ff.pins_sync;

    // Edge spacing monitors for the generated clocks
    vchanged = clk_if.vclk_p != st_ff.vclk_q;
    achanged = clk_if.aclk512 != st_ff.a512_q;
    nxt_st.vclk_q = clk_if.vclk_p;
    nxt_st.div_q = clk_if.div_sel;
    nxt_st.vgap = vchanged ? {2'h0, i_video_tick} :
                  3'(st_ff.vgap + {2'h0, i_video_tick});
    if (clk_if.div_sel != st_ff.div_q)
    begin
      nxt_st.vsettle = 1'b0;
    end
    else if (vchanged)
    begin
      nxt_st.vsettle = 1'b1;
    end
    nxt_st.a512_q = clk_if.aclk512;
    nxt_st.mode_q = third_duty;
    nxt_st.agap = achanged ? {1'h0, i_aclk512_tick} :
                  2'(st_ff.agap + {1'h0, i_aclk512_tick});
    if (third_duty != st_ff.mode_q)
    begin
      nxt_st.asettle = 1'b0;
    end
    else if (achanged)
    begin
      nxt_st.asettle = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff.bus <= cao_pkg::CAO_BUS_IDLE;
      st_ff.rdata <= 32'h0;
      st_ff.phase_div <= cao_pkg::PHASE_DIV_RST;
      st_ff.hiz <= cao_pkg::HIZ_RST;
      st_ff.audio <= cao_pkg::AUDIO_RST;
      st_ff.rate_reg <= cao_pkg::RATE_RST;
      st_ff.rate_written <= 1'b0;
      st_ff.pins_meta <= 3'h0;
      st_ff.pins_sync <= 3'h0;
      st_ff.rate_eff <= 3'h0;
      st_ff.vclk_q <= 1'b0;
      st_ff.div_q <= 2'h0;
      st_ff.vgap <= 3'h0;
      st_ff.vsettle <= 1'b0;
      st_ff.a512_q <= 1'b0;
      st_ff.mode_q <= 1'b0;
      st_ff.agap <= 2'h0;
      st_ff.asettle <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  assign o_avs_waitrequest = bus_req && (st_ff.bus != cao_pkg::CAO_BUS_ACK);
  assign o_avs_readdata = st_ff.rdata;
  assign o_diff_video_clock_out_p = clk_if.vclk_p;
  assign o_diff_video_clock_out_n = clk_if.vclk_n;
  assign o_diff_video_clock_out_oe = st_ff.hiz != cao_pkg::HIZ_OFF;
  // Delay line sits outside; the core clock is far too slow for 700ps
  assign o_diff_clk_phase_sel =
    st_ff.phase_div[cao_pkg::PHASE_MSB:cao_pkg::PHASE_LSB];
  assign o_frame_seq_drift_window =
    st_ff.audio[cao_pkg::WINDOW_MSB:cao_pkg::WINDOW_LSB];
  assign o_mid_audio_clock_enable = st_ff.audio[cao_pkg::MID_EN_BIT];
  assign o_audio_rate = st_ff.rate_eff;
  assign o_aclk512 = clk_if.aclk512;
  assign o_aclk384 = clk_if.aclk384;
  assign o_aclk192 = clk_if.aclk192;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_quarter_rate: assert property (
    vchanged && st_ff.vsettle && clk_if.div_sel == st_ff.div_q &&
    clk_if.div_sel == 2'h2 |-> st_ff.vgap == 3'h4)
    else $error("quarter rate clock edge spacing wrong");

  a_half_rate: assert property (
    vchanged && st_ff.vsettle && clk_if.div_sel == st_ff.div_q &&
    clk_if.div_sel == 2'h1 |-> st_ff.vgap == 3'h2)
    else $error("half rate clock edge spacing wrong");

  a_full_rate: assert property (
    vchanged && st_ff.vsettle && clk_if.div_sel == st_ff.div_q &&
    clk_if.div_sel == 2'h3 |-> st_ff.vgap == 3'h1)
    else $error("full rate clock edge spacing wrong");

  a_phase_write: assert property (
    wr_ack && i_avs_byteenable[0] &&
    i_avs_address == cao_pkg::reg_addr(cao_pkg::IDX_PHASE_DIV)
    |=> o_diff_clk_phase_sel == $past(i_avs_writedata[5:2]))
    else $error("phase select did not follow write");

  a_hiz_pins: assert property (
    wr_ack && i_avs_byteenable[0] &&
    i_avs_address == cao_pkg::reg_addr(cao_pkg::IDX_HIZ)
    |=> o_diff_video_clock_out_oe == ($past(i_avs_writedata[1:0]) != 2'h3))
    else $error("pair enable does not match written code");

  a_window_write: assert property (
    wr_ack && i_avs_byteenable[1:0] == 2'h3 &&
    i_avs_address == cao_pkg::reg_addr(cao_pkg::IDX_AUDIO)
    |=> o_frame_seq_drift_window == $past(i_avs_writedata[9:7]))
    else $error("drift window did not follow write");

  a_mid_gated: assert property (
    !o_mid_audio_clock_enable && !$past(o_mid_audio_clock_enable)
    |-> !o_aclk384 && !o_aclk192)
    else $error("mid audio clocks run while disabled");

  a_third_duty: assert property (
    achanged && st_ff.asettle && third_duty && st_ff.mode_q
    |-> st_ff.agap == (o_aclk512 ? 2'h2 : 2'h1))
    else $error("512fs clock not at one third duty");

  a_rate_select: assert property (
    ##1 $stable(st_ff.audio) && $stable(st_ff.rate_reg)
    ##1 $stable(st_ff.audio) && $stable(st_ff.rate_reg)
    |-> o_audio_rate == (st_ff.audio[cao_pkg::HOST_RATE_BIT] ?
                         st_ff.rate_reg : $past(st_ff.pins_sync)))
    else $error("effective rate source wrong");

  a_rate_default: assert property (
    !st_ff.rate_written |-> st_ff.rate_reg == cao_pkg::RATE_RST)
    else $error("host rate code lost its default");

  a_rate_write: assert property (
    wr_ack && i_avs_byteenable[0] &&
    i_avs_address == cao_pkg::reg_addr(cao_pkg::IDX_RATE)
    |=> st_ff.rate_reg == $past(i_avs_writedata[2:0]))
    else $error("host rate code did not follow write");

  a_mid_running: assert property (
    $past(o_mid_audio_clock_enable) && $past(i_mid_tick)
    |-> o_aclk384 != $past(o_aclk384))
    else $error("384fs clock did not toggle on its tick");

  // Masters may count on exactly one wait cycle per access
  a_bus_one_wait: assert property (
    o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("register access took more than one wait cycle");

endmodule

// >>> testbench/cao_consumer_model.sv
`timescale 1ns/100ps
// ==========================================================
// Tick source and downstream clock consumer
module cao_consumer_model
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Control from bench
  input wire logic i_slow,
  input wire logic i_count,
  // Ticks to the block
  output logic o_tick,
  // Clocks from the block: 192fs, 384fs, 512fs, pair positive
  input wire logic [3:0] i_clks,
  input wire logic i_n,
  input wire logic i_oe,
  // Toggles seen in the window, and polarity faults
  output logic [7:0] o_cnt [4],
  output logic [7:0] o_bad
);
  logic phase_ff;
  logic [3:0] last_ff;

  // Slow mode ticks every other cycle, as a slower synthesiser would
  assign o_tick = i_slow ? phase_ff : 1'b1;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      phase_ff <= 1'b0;
      last_ff <= 4'h0;
      o_bad <= 8'h00;
      for (int k = 0; k < 4; k++)
        o_cnt[k] <= 8'h00;
    end
    else
    begin
      phase_ff <= ~phase_ff;
      last_ff <= i_clks;
      if (i_count && i_oe && i_n === i_clks[0])
        o_bad <= o_bad + 8'h01;
      for (int k = 0; k < 4; k++)
        if (!i_count)
          o_cnt[k] <= 8'h00;
        else if (i_clks[k] !== last_ff[k])
          o_cnt[k] <= o_cnt[k] + 8'h01;
    end
  end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb;
  localparam logic [2:0] RATE_96K = 3'h5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic waitreq;
  logic [2:0] pins = 3'h0;
  logic slow = 1'b0;
  logic count = 1'b0;
  logic tick, p, n, oe, a512, a384, a192, mid_en;
  logic [3:0] phase;
  logic [2:0] window, rate;
  logic [7:0] cnt [4];
  logic [7:0] bad;
  logic [31:0] q;
  logic [7:0] div_exp [4] = '{8'h30, 8'h18, 8'h0C, 8'h30};
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  // ==========================================================
  // Design and partner
  cao_clock_output_audio_ctrl #(.RATE_CODE_96K(RATE_96K)) dut
  (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_avs_address(address),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_video_tick(tick),
    .i_aclk512_tick(tick), .i_mid_tick(tick), .i_audio_rate_pins(pins),
    .o_diff_video_clock_out_p(p), .o_diff_video_clock_out_n(n),
    .o_diff_video_clock_out_oe(oe), .o_diff_clk_phase_sel(phase),
    .o_frame_seq_drift_window(window), .o_mid_audio_clock_enable(mid_en),
    .o_audio_rate(rate), .o_aclk512(a512), .o_aclk384(a384),
    .o_aclk192(a192)
  );

  cao_consumer_model peer
  (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_count(count),
    .o_tick(tick), .i_clks({a192, a384, a512, p}), .i_n(n), .i_oe(oe),
    .o_cnt(cnt), .o_bad(bad)
  );

  // ==========================================================
  // Tasks
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request stands until waitrequest is seen low at a rising edge;
  // the idle edge after release keeps two calls from overlapping
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d,
    input logic [3:0] lanes);
    int k;
    k = 0;
    address <= a;
    rd <= !w;
    wr <= w;
    wdata <= {16'hA5A5, d};
    be <= lanes;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (waitreq !== 1'b0);
    q = rdata;
    chk(k, 32'h2);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0000, 4'h3);
    chk(q, exp);
  endtask

  task measure(input logic [7:0] e_p, e_512, e_384, e_192);
    repeat (8) @(posedge clk);
    count <= 1'b1;
    repeat (48) @(posedge clk);
    count <= 1'b0;
    @(negedge clk);
    chk({cnt[0], cnt[1], cnt[2], cnt[3]}, {e_p, e_512, e_384, e_192});
    @(posedge clk);
  endtask

  task end_test(input string name);
    $display("test %0s done", name);
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      complete_run;
    end
  end

  // ==========================================================
  // Tests
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(8'hB8, 32'h0);
    rd_chk(8'hBC, 32'h0);
    rd_chk(8'hC4, 32'h100);
    rd_chk(8'hC8, 32'h3);
    chk({23'h0, window, mid_en, oe, phase}, 32'h090);
    end_test("reset");
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'hB8, {10'h0, 4'(i * 5), 2'(i)}, 4'h3);
      measure(div_exp[i], 8'h30, 8'h00, 8'h00);
      chk({28'h0, phase}, 32'(i * 5));
      rd_chk(8'hB8, 32'(i * 21));
    end
    slow <= 1'b1;
    bus(1'b1, 8'hB8, 16'h0002, 4'h3);
    measure(8'h06, 8'h18, 8'h00, 8'h00);
    slow <= 1'b0;
    end_test("divide");
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'hBC, {14'h0, 2'(i)}, 4'h3);
      chk({31'h0, oe}, {31'h0, i != 3});
      rd_chk(8'hBC, 32'(i));
    end
    bus(1'b1, 8'hBC, 16'h0000, 4'h3);
    end_test("hiz");
    pins <= 3'h6;
    bus(1'b1, 8'hC4, 16'h0220, 4'h3);
    measure(8'h0C, 8'h30, 8'h30, 8'h18);
    chk({25'h0, window, mid_en, rate}, 32'h4E);
    bus(1'b1, 8'hC8, {13'h0, RATE_96K}, 4'h3);
    bus(1'b1, 8'hC4, 16'h0224, 4'h3);
    pins <= 3'h7;
    measure(8'h0C, 8'h20, 8'h30, 8'h18);
    chk({29'h0, rate}, {29'h0, RATE_96K});
    bus(1'b1, 8'hC4, 16'hFF00, 4'h1);
    measure(8'h0C, 8'h30, 8'h00, 8'h00);
    rd_chk(8'hC4, 32'h200);
    chk({29'h0, rate}, 32'h7);
    bus(1'b1, 8'hC4, 16'h03A4, 4'h3);
    rd_chk(8'hC4, 32'h3A4);
    end_test("audio");
    bus(1'b1, 8'hC0, 16'h1234, 4'h3);
    rd_chk(8'hC0, 32'h0);
    rd_chk(8'h00, 32'h0);
    rd_chk(8'hC8, {29'h0, RATE_96K});
    chk({24'h0, bad}, 32'h0);
    end_test("unmapped");
    complete_run;
  end
endmodule
